// ==== include/cdac_pkg.sv ====
package cdac_pkg;

    // special function register addresses
    localparam logic [7:0] CDAC_ADDR_DATA_LOW  = 8'h96;
    localparam logic [7:0] CDAC_ADDR_DATA_HIGH = 8'h97;
    localparam logic [7:0] CDAC_ADDR_CONTROL   = 8'hb9;

    // control and low data register field positions
    localparam int CDAC_EN_BIT      = 7;
    localparam int CDAC_SRC_MSB     = 6;
    localparam int CDAC_SRC_LSB     = 4;
    localparam int CDAC_FS_MSB      = 1;
    localparam int CDAC_FS_LSB      = 0;
    localparam int CDAC_LOW_MSB     = 7;
    localparam int CDAC_LOW_LSB     = 6;

    // values after reset
    localparam logic [7:0] CDAC_CONTROL_RESET = 8'h72;
    localparam logic [7:0] CDAC_HIGH_RESET    = 8'h00;
    localparam logic [1:0] CDAC_LOW_RESET     = 2'h0;
    localparam logic [9:0] CDAC_LATCH_RESET   = 10'h000;
    localparam logic [2:0] CDAC_PIN_RESET     = 3'h0;
    localparam logic [7:0] CDAC_RDATA_RESET   = 8'h00;

    // control bits 3:2 hold no state and always read as zero
    localparam logic [7:0] CDAC_CTRL_WMASK    = 8'hf3;

    localparam int CDAC_WORD_W  = 10;
    localparam int CDAC_TIMER_N = 4;

    // update source codes
    localparam logic [2:0] CDAC_SRC_PIN_RISE  = 3'h4;
    localparam logic [2:0] CDAC_SRC_PIN_FALL  = 3'h5;
    localparam logic [2:0] CDAC_SRC_PIN_ANY   = 3'h6;
    localparam logic [2:0] CDAC_SRC_HIGH_WR   = 3'h7;

    // full-scale current range, decoded
    typedef enum logic [1:0] {
        CDAC_FS_0P5MA = 2'h0,
        CDAC_FS_1MA   = 2'h1,
        CDAC_FS_2MA   = 2'h2
    } cdac_range_t;

    // decode of the control reset value: upper range bit set
    localparam cdac_range_t CDAC_RANGE_RESET = CDAC_FS_2MA;

    // register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cdac_sfr_req_t;

    // what the analog converter is given
    typedef struct packed {
        logic        enable;
        cdac_range_t range;
        logic [9:0]  code;
    } cdac_analog_t;

endpackage

// ==== src/cdac_update_ctrl.sv ====
`timescale 1ns/100ps
// Operation
// - codes 000-011 update on timer 0-3 overflow
// - codes 100/101 update on pin rise/fall
// - code 110 updates on any pin edge
// - code 111 updates on high-byte write; reset
// - range code 00 selects half milliamp
// - code 01 one milliamp; 1x two milliamp
// - high byte holds word bits 9:2
// - low byte bits 7:6 hold word 1:0
// - control bits 3:2 read zero, ignored
// - low byte bits 5:0 read zero, ignored
// - enable bit switches converter; else gpio
// - enabled: pin driver, pull-up off, connected
// - write mode: low write waits for high
// - other modes: latch only on event
module cdac_update_ctrl
    import cdac_pkg::*;
#(
    parameter int TIMER_N = CDAC_TIMER_N, // timer overflow inputs, one per timer
    parameter int WORD_W  = CDAC_WORD_W   // converter word width
)
(
    input  wire logic               ref_clk_in,        // system clock, 125 MHz
    input  wire logic               nrst_in,           // async reset, active low
    input  wire logic               clk_en_in,         // freezes all state when low
    input  wire cdac_sfr_req_t      sfr_req_in,        // register access strobes
    output logic [7:0]              sfr_rdata_out,     // read data, registered
    output logic                    sfr_hit_out,       // address matched, registered
    input  wire logic [TIMER_N-1:0] timer_ovf_in,      // timer overflow pulses
    input  wire logic               conv_start_pin_in, // external start pin
    output cdac_analog_t            analog_out,        // converter controls
    output logic                    update_strobe_out, // latches loaded this cycle
    output logic                    gpio_release_out   // pin handed to converter
);

    // control and data registers
    logic [7:0]        ctrl_q, ctrl_d;
    logic [7:0]        high_q, high_d;
    logic [1:0]        low_q, low_d;
    cdac_range_t       range_q, range_d;

    // converter input latches and their load strobe
    logic [WORD_W-1:0] latch_q, latch_d;
    logic              upd_q, upd_d;

    // start pin: two synchroniser stages, then one history stage
    logic [2:0]        pin_q, pin_d;

    // read response
    logic [7:0]        rdata_q, rdata_d;
    logic              hit_q, hit_d;

    // decode
    logic [2:0]        src;
    logic              wr_ctrl, wr_high, wr_low;
    logic              rise, fall, event_sel;
    logic [WORD_W-1:0] word;

    // the source field names a timer with two bits and the word is split over two
    // fixed byte registers, so no other counts or widths can be served
    if (TIMER_N != CDAC_TIMER_N) begin : g_bad_timer_n
        $error("timer count must be 4");
    end
    if (WORD_W != CDAC_WORD_W) begin : g_bad_word_w
        $error("word width must be 10");
    end

    assign src     = ctrl_q[CDAC_SRC_MSB:CDAC_SRC_LSB];
    assign wr_ctrl = sfr_req_in.wr && (sfr_req_in.addr == CDAC_ADDR_CONTROL);
    assign wr_high = sfr_req_in.wr && (sfr_req_in.addr == CDAC_ADDR_DATA_HIGH);
    assign wr_low  = sfr_req_in.wr && (sfr_req_in.addr == CDAC_ADDR_DATA_LOW);

    // pin_q[1] is the second synchroniser stage, pin_q[2] the edge history;
    // the first stage may still be settling, so nothing else reads it
    assign rise = pin_q[1] && !pin_q[2];
    assign fall = !pin_q[1] && pin_q[2];

    always_comb begin
        case (src)
            CDAC_SRC_PIN_RISE: event_sel = rise;
            CDAC_SRC_PIN_FALL: event_sel = fall;
            CDAC_SRC_PIN_ANY:  event_sel = rise || fall;
            CDAC_SRC_HIGH_WR:  event_sel = wr_high;
            default:           event_sel = timer_ovf_in[src[1:0]];
        endcase
    end

    // ---- control and data registers
    always_comb begin
        ctrl_d = ctrl_q;
        high_d = high_q;
        low_d  = low_q;
        if (wr_ctrl) begin
            ctrl_d = sfr_req_in.wdata & CDAC_CTRL_WMASK;
        end
        if (wr_high) begin
            high_d = sfr_req_in.wdata;
        end
        if (wr_low) begin
            low_d = sfr_req_in.wdata[CDAC_LOW_MSB:CDAC_LOW_LSB];
        end
        // range is decoded ahead of the register so the output comes from a flop;
        // upper bit set wins regardless of the lower bit
        if (ctrl_d[CDAC_FS_MSB]) begin
            range_d = CDAC_FS_2MA;
        end else if (ctrl_d[CDAC_FS_LSB]) begin
            range_d = CDAC_FS_1MA;
        end else begin
            range_d = CDAC_FS_0P5MA;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q  <= CDAC_CONTROL_RESET;
            high_q  <= CDAC_HIGH_RESET;
            low_q   <= CDAC_LOW_RESET;
            range_q <= CDAC_RANGE_RESET;
        end else if (clk_en_in) begin
            ctrl_q  <= ctrl_d;
            high_q  <= high_d;
            low_q   <= low_d;
            range_q <= range_d;
        end
    end

    // ---- start pin synchroniser
    always_comb begin
        pin_d = {pin_q[1:0], conv_start_pin_in};
    end

    // a pin that idles high shows one false rise after reset; harmless while the
    // reset source is the high-byte write
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_q <= CDAC_PIN_RESET;
        end else if (clk_en_in) begin
            pin_q <= pin_d;
        end
    end

    // ---- converter input latches
    // a high-byte write that triggers the update carries its new data straight in,
    // so software sees the word it just completed rather than the old one
    always_comb begin
        word    = {(wr_high ? sfr_req_in.wdata : high_q), low_q};
        latch_d = latch_q;
        upd_d   = 1'b0;
        if (event_sel) begin
            latch_d = word;
            upd_d   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_q <= CDAC_LATCH_RESET;
            upd_q   <= 1'b0;
        end else if (clk_en_in) begin
            latch_q <= latch_d;
            upd_q   <= upd_d;
        end
    end

    // ---- read response, one cycle after the strobe
    always_comb begin
        hit_d   = 1'b0;
        rdata_d = CDAC_RDATA_RESET;
        if (sfr_req_in.rd) begin
            case (sfr_req_in.addr)
                CDAC_ADDR_CONTROL: begin
                    hit_d   = 1'b1;
                    rdata_d = ctrl_q & CDAC_CTRL_WMASK;
                end
                CDAC_ADDR_DATA_HIGH: begin
                    hit_d   = 1'b1;
                    rdata_d = high_q;
                end
                CDAC_ADDR_DATA_LOW: begin
                    hit_d   = 1'b1;
                    rdata_d = {low_q, 6'h00};
                end
                default: begin
                    hit_d   = 1'b0;
                    rdata_d = CDAC_RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= CDAC_RDATA_RESET;
            hit_q   <= 1'b0;
        end else if (clk_en_in) begin
            rdata_q <= rdata_d;
            hit_q   <= hit_d;
        end
    end

    // ---- outputs
    // one assignment for the whole struct keeps a single driver on it
    assign analog_out = '{enable: ctrl_q[CDAC_EN_BIT], range: range_q, code: latch_q};
    // digital driver and pull-up are released while converter owns the pin
    assign gpio_release_out  = ctrl_q[CDAC_EN_BIT];
    assign update_strobe_out = upd_q;
    assign sfr_rdata_out     = rdata_q;
    assign sfr_hit_out       = hit_q;

endmodule

// ==== verification/cdac_update_ctrl_checker.sv ====
`timescale 1ns/100ps
module cdac_checker
    import cdac_pkg::*;
(
    input wire logic          ref_clk_in,        // clk
    input wire logic          nrst_in,           // rst
    input wire logic          clk_en_in,         // en
    input wire cdac_sfr_req_t sfr_req_in,        // bus
    input wire logic [7:0]    sfr_rdata_out,     // rd
    input wire logic          sfr_hit_out,       // hit
    input wire logic [3:0]    timer_ovf_in,      // ovf
    input wire logic          conv_start_pin_in, // pin
    input wire cdac_analog_t  analog_out,        // dac
    input wire logic          update_strobe_out, // stb
    input wire logic          gpio_release_out   // rel
);
    logic [2:0] src_q;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // shadow of the source field, so each event check knows the mode
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) src_q <= 3'h7;
        else if (clk_en_in && sfr_req_in.wr && sfr_req_in.addr == 8'hb9)
            src_q <= sfr_req_in.wdata[6:4];
    end
    sequence s_hi_wr;
        clk_en_in && sfr_req_in.wr && sfr_req_in.addr == 8'h97 && src_q == 3'h7;
    endsequence
    a_gpio_enable: assert property (gpio_release_out == analog_out.enable)
        else $error("release differs from enable");
    a_ctrl_read: assert property (sfr_hit_out && $past(sfr_req_in.addr) == 8'hb9
        && !$past(sfr_req_in.wr) |-> sfr_rdata_out[3:2] == 2'h0
        && analog_out.range == (sfr_rdata_out[1] ? 2'h2 : {1'b0, sfr_rdata_out[0]}))
        else $error("control read or range wrong");
    a_low_zero: assert property (sfr_hit_out && $past(sfr_req_in.addr) == 8'h96
        |-> sfr_rdata_out[5:0] == 6'h00) else $error("low byte unused bits set");
    a_code_hold: assert property (!update_strobe_out |-> $stable(analog_out.code))
        else $error("code moved without strobe");
    a_write_update: assert property (s_hi_wr |=> update_strobe_out
        && analog_out.code[9:2] == $past(sfr_req_in.wdata)) else $error("high write lost");
    a_timer_update: assert property (clk_en_in && src_q < 3'h4
        && timer_ovf_in[src_q[1:0]] |=> update_strobe_out) else $error("timer update lost");
    a_timer_only: assert property (src_q < 3'h4 && !timer_ovf_in[src_q[1:0]]
        |=> !update_strobe_out) else $error("update without timer");
    a_pin_rise: assert property (src_q == 3'h4 && $rose(conv_start_pin_in)
        |-> ##[1:5] update_strobe_out) else $error("rise update lost");
    a_pin_any: assert property (src_q == 3'h6 && $changed(conv_start_pin_in)
        |-> ##[1:5] update_strobe_out) else $error("edge update lost");
endmodule

// ==== verification/test_current_dac_update_control.sv ====
`timescale 1ns/100ps
module test_current_dac_update_control import cdac_pkg::*;;
    logic          ref_clk_in = 1'b0;
    logic          nrst_in = 1'b0;
    cdac_sfr_req_t req = '0;
    logic [3:0]    tov = 4'h0;
    logic          pin = 1'b0;
    logic          en = 1'b1;
    logic [7:0]    rdata;
    logic          hit, stb, rel;
    cdac_analog_t  an;
    int            mismatches = 0;
    int            comparisons = 0;
    int            cycles = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    cdac_update_ctrl DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(en),
        .sfr_req_in(req), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .timer_ovf_in(tov),
        .conv_start_pin_in(pin), .analog_out(an), .update_strobe_out(stb),
        .gpio_release_out(rel));
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk_in) req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in) req <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        logic h;
        h = (a == 8'h96) || (a == 8'h97) || (a == 8'hb9);
        @(posedge ref_clk_in) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_in) req <= '0;
        #1 check("rdata", {2'h0, rdata}, {2'h0, exp});
        check("hit", {9'h000, hit}, {9'h000, h});
    endtask
    task automatic pulse(logic [3:0] v);
        @(posedge ref_clk_in) tov <= v;
        @(posedge ref_clk_in) tov <= 4'h0;
    endtask
    task automatic wait_code(int n, logic [9:0] exp);
        repeat (n) @(posedge ref_clk_in);
        #1 check("code", an.code, exp);
    endtask
    task automatic t_reset_write();
        rd(8'hb9, 8'h72);
        rd(8'h97, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h96, 8'hff);
        rd(8'h96, 8'hc0);
        wait_code(1, 10'h000);
        wr(8'h97, 8'hab);
        wait_code(1, 10'h2af);
        wr(8'h96, 8'h40);
        wait_code(2, 10'h2af);
    endtask
    task automatic t_ctrl();
        wr(8'hb9, 8'h8d);
        rd(8'hb9, 8'h81);
        check("range", an.range, 2'h1);
        check("release", rel, 1'b1);
        wr(8'hb9, 8'h7f);
        rd(8'hb9, 8'h73);
        check("range", an.range, 2'h2);
        wr(8'hb9, 8'h00);
        // the control register loads on this edge, so look once it has settled
        #1 check("range", an.range, 2'h0);
        check("release", rel, 1'b0);
    endtask
    task automatic t_freeze();
        wr(8'hb9, 8'hf2);
        @(posedge ref_clk_in) en <= 1'b0;
        wr(8'h97, 8'h3c);
        wait_code(1, 10'h185);
        @(posedge ref_clk_in) en <= 1'b1;
        rd(8'h97, 8'h61);
        rd(8'hb9, 8'hf2);
    endtask
    task automatic t_events();
        logic [9:0] e;
        e = 10'h2af;
        for (int s = 0; s < 7; s++) begin
            wr(8'hb9, {1'b1, s[2:0], 4'h2});
            for (int k = 0; k < 2; k++) begin
                wr(8'h97, {s[3:0], k[3:0]});
                if (s < 4) pulse(k == 0 ? ~(4'h1 << s) : 4'h1 << s);
                else @(posedge ref_clk_in) pin <= ~pin;
                if (s == 6 || s == 4 + k || (s < 4 && k == 1)) e = {s[3:0], k[3:0], 2'h1};
                // the pin passes a synchroniser, so allow it several cycles
                wait_code(6, e);
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        t_reset_write();
        t_ctrl();
        t_events();
        t_freeze();
        print_verdict();
    end
endmodule
bind cdac_update_ctrl cdac_checker u_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in), .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
    .sfr_hit_out(sfr_hit_out), .timer_ovf_in(timer_ovf_in),
    .conv_start_pin_in(conv_start_pin_in), .analog_out(analog_out),
    .update_strobe_out(update_strobe_out), .gpio_release_out(gpio_release_out));
